// ==== core/spc_sleep_ctrl.v ====
// sleep mode, clock gating and detector control with an AHB-Lite register port
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`include "spc_regs.vh"

// Contract
// - mode 00 enters idle, stops cpu and flash
// - any enabled interrupt wakes from idle
// - idle or noise mode starts enabled converter
// - mode 01 stops io, cpu, flash clocks
// - noise mode wakes on listed sources only
// - mode 10 stops oscillator and all clocks
// - power-down wakes on listed sources only
// - requested detector off at power-down entry
// - wake-up re-enables the detector
// - detector off means reset-length wake delay
// - detector-off bit: one off, resets zero
// - detector-off bit changes only via sequence
// - gated module: clock stops, access blocked
// - ungating restarts clock, state kept
// - module gating matters in active, idle
// - converter stays enabled; re-enable gives extended
// - power-down disables comparator unless internal ref
// - io and adc stopped disables input buffers
// - reference on while detector, comparator, converter need
// - sleep only when sleep permit set
// - unlock, then set within four; three-cycle timing
// - cpu halted four cycles after start-up
module spc_sleep_ctrl #(
  parameter [15:0]          OSC_CYC  = (`SPC_T_OSC_NS * `SPC_CLK_MHZ + 999) / 1000,
  parameter [15:0]          RST_CYC  = (`SPC_T_RST_NS * `SPC_CLK_MHZ + 999) / 1000,
  parameter [`SPC_PIN_W-1:0] WAKE_PINS = 6'h3F
) (
  input  wire                   ref_clk_i,       // system clock
  input  wire                   rst_n_i,         // sync reset, low
  input  wire                   clk_en_i,        // freezes all state when low
  input  wire                   hsel_i,          // ahb select
  input  wire [`SPC_AW-1:0]     haddr_i,         // ahb address
  input  wire [1:0]             htrans_i,        // ahb transfer type
  input  wire                   hwrite_i,        // ahb write
  input  wire [2:0]             hsize_i,         // ahb size
  input  wire [31:0]            hwdata_i,        // ahb write data
  input  wire                   hready_i,        // ahb ready in
  output reg  [31:0]            hrdata_o,        // ahb read data
  output reg                    hreadyout_o,     // ahb ready out
  output reg                    hresp_o,         // ahb response
  input  wire                   sleep_instr_i,   // sleep instruction pulse
  input  wire                   irq_any_i,       // any enabled interrupt
  input  wire                   adc_done_i,      // conversion complete irq
  input  wire                   nvm_ready_i,     // self-program/nvm ready irq
  input  wire                   ext0_level_i,    // level irq on external_irq_zero
  input  wire                   pin_change_i,    // pin change irq
  input  wire                   serial_start_i,  // universal_serial_unit start
  input  wire [1:0]             det_fuse_i,      // detector_level_fuse
  input  wire                   adc_en_i,        // converter enabled
  input  wire                   acmp_en_i,       // comparator enabled
  input  wire                   acmp_iref_i,     // comparator on internal ref
  output reg                    cpu_clk_en_o,    // cpu clock enable
  output reg                    flash_clk_en_o,  // flash clock enable
  output reg                    io_clk_en_o,     // io clock enable
  output reg                    adc_clk_en_o,    // adc clock enable
  output reg                    osc_en_o,        // main oscillator enable
  output reg  [`SPC_GATE_W-1:0] mod_clk_en_o,    // per-module clock enable
  output reg  [`SPC_GATE_W-1:0] mod_acc_en_o,    // per-module register access
  output reg                    adc_start_o,     // start conversion pulse
  output reg                    adc_ext_o,       // next conversion extended
  output reg                    det_en_o,        // brownout_detector enable
  output reg                    acmp_off_o,      // comparator forced off
  output reg                    vref_en_o,       // internal reference enable
  output reg  [`SPC_PIN_W-1:0]  pin_buf_en_o     // digital input buffer enables
);

  localparam [1:0] ST_RUN   = 2'h0;
  localparam [1:0] ST_SLEEP = 2'h1;
  localparam [1:0] ST_START = 2'h2;
  localparam [1:0] ST_HALT  = 2'h3;

  // wake decode per mode
  function spc_wake;
    input [1:0] mode;
    input       any;
    input       adc;
    input       nvm;
    input       ext0;
    input       pcint;
    input       ser;
    begin
      case (mode)
        `SPC_MODE_IDLE: spc_wake = any;
        `SPC_MODE_NR:   spc_wake = adc | nvm | ext0 | pcint;
        `SPC_MODE_PD:   spc_wake = ser | ext0 | pcint;
        default:        spc_wake = 1'b0;
      endcase
    end
  endfunction

  // async pins: two flops before use
  reg  [4:0] sync1_q;
  reg  [4:0] sync2_q;
  wire       ext0_s  = sync2_q[0];
  wire       pcint_s = sync2_q[1];
  wire       ser_s   = sync2_q[2];
  wire [1:0] fuse_s  = sync2_q[4:3];

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else if (clk_en_i) begin
      sync1_q <= {det_fuse_i, serial_start_i, pin_change_i, ext0_level_i};
      sync2_q <= sync1_q;
    end
  end

  // bus: address phase capture, data phase apply
  reg               wr_q;
  reg [`SPC_AW-1:0] addr_q;
  wire              take = hsel_i & htrans_i[1] & hready_i;

  // control registers
  reg                   permit_q;
  reg [1:0]             sel_q;
  reg [`SPC_GATE_W-1:0] gate_q;
  reg [2:0]             unlock_cnt_q;
  reg [2:0]             pend_cnt_q;
  reg [2:0]             act_cnt_q;
  reg                   off_q;

  wire       ctrl_wr  = wr_q & (addr_q == `SPC_A_CTRL);
  wire       gate_wr  = wr_q & (addr_q == `SPC_A_GATE);
  wire       w_off    = hwdata_i[`SPC_B_OFF];
  wire       w_unlock = hwdata_i[`SPC_B_UNLOCK];
  wire       seq_arm  = ctrl_wr & w_off & w_unlock;
  wire       seq_set  = ctrl_wr & w_off & ~w_unlock & (unlock_cnt_q != 3'h0);

  // sleep state
  reg [1:0]  st_q;
  reg [1:0]  mode_q;
  reg [15:0] cnt_q;
  reg        det_slept_q;
  reg        adc_en_q;

  wire sleep_go = (st_q == ST_RUN) & sleep_instr_i & permit_q & (sel_q != `SPC_MODE_RSV);
  wire wake     = (st_q == ST_SLEEP) &
                  spc_wake(mode_q, irq_any_i, adc_done_i, nvm_ready_i, ext0_s, pcint_s, ser_s);

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_q         <= 1'b0;
      addr_q       <= {`SPC_AW{1'b0}};
      permit_q     <= 1'b0;
      sel_q        <= `SPC_MODE_IDLE;
      gate_q       <= {`SPC_GATE_W{1'b0}};
      unlock_cnt_q <= 3'h0;
      pend_cnt_q   <= 3'h0;
      act_cnt_q    <= 3'h0;
      off_q        <= 1'b0;
    end else if (clk_en_i) begin
      wr_q   <= take & hwrite_i;
      addr_q <= haddr_i;
      if (ctrl_wr) begin
        permit_q <= hwdata_i[`SPC_B_PERMIT];
        sel_q    <= hwdata_i[`SPC_B_MODE_HI:`SPC_B_MODE_LO];
      end
      if (gate_wr)
        gate_q <= hwdata_i[`SPC_GATE_W-1:0];
      // off bit itself is never written directly
      if (seq_arm)
        unlock_cnt_q <= `SPC_UNLOCK_WIN;
      else if (seq_set)
        unlock_cnt_q <= 3'h0;
      else if (unlock_cnt_q != 3'h0)
        unlock_cnt_q <= unlock_cnt_q - 3'h1;
      if (seq_set)
        pend_cnt_q <= `SPC_OFF_DELAY;
      else if (pend_cnt_q != 3'h0)
        pend_cnt_q <= pend_cnt_q - 3'h1;
      if (pend_cnt_q == 3'h1) begin
        off_q     <= 1'b1;
        act_cnt_q <= `SPC_OFF_HOLD;
      end else if (act_cnt_q != 3'h0) begin
        act_cnt_q <= act_cnt_q - 3'h1;
        if (act_cnt_q == 3'h1)
          off_q <= 1'b0;
      end
    end
  end

  // sleep sequencing
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q        <= ST_RUN;
      mode_q      <= `SPC_MODE_IDLE;
      cnt_q       <= 16'h0000;
      det_slept_q <= 1'b0;
    end else if (clk_en_i) begin
      case (st_q)
        ST_RUN: begin
          if (sleep_go) begin
            st_q        <= ST_SLEEP;
            mode_q      <= sel_q;
            det_slept_q <= (sel_q == `SPC_MODE_PD) & off_q;
          end
        end
        ST_SLEEP: begin
          if (wake) begin
            det_slept_q <= 1'b0;
            if (mode_q == `SPC_MODE_PD) begin
              st_q  <= ST_START;
              cnt_q <= det_slept_q ? RST_CYC : OSC_CYC;
            end else begin
              st_q  <= ST_HALT;
              cnt_q <= `SPC_HALT_CYC;
            end
          end
        end
        ST_START: begin
          if (cnt_q <= 16'h0001) begin
            st_q  <= ST_HALT;
            cnt_q <= `SPC_HALT_CYC;
          end else
            cnt_q <= cnt_q - 16'h0001;
        end
        ST_HALT: begin
          if (cnt_q <= 16'h0001)
            st_q <= ST_RUN;
          else
            cnt_q <= cnt_q - 16'h0001;
        end
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // clock domains derived from state and captured mode
  wire in_sleep = (st_q == ST_SLEEP);
  wire deep     = (mode_q == `SPC_MODE_PD) & (in_sleep | (st_q == ST_START));
  wire io_on    = ~deep & ~(in_sleep & (mode_q == `SPC_MODE_NR));
  wire adc_on   = ~deep;
  wire det_fuse = (fuse_s != `SPC_FUSE_OFF);
  wire det_on   = det_fuse & ~det_slept_q;
  wire acmp_dis = in_sleep & (mode_q == `SPC_MODE_PD) & ~acmp_iref_i;
  wire acmp_ref = acmp_en_i & acmp_iref_i & ~acmp_dis;
  wire buf_off  = ~io_on & ~adc_on;

  wire [`SPC_GATE_W-1:0] dom_on;
  assign dom_on = {{(`SPC_GATE_W-1){io_on}}, adc_on};

  wire [31:0] stat = {24'h000000, ~buf_off, vref_en_o, det_en_o, mode_q, in_sleep, st_q};

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hrdata_o       <= 32'h00000000;
      hreadyout_o    <= 1'b1;
      hresp_o        <= 1'b0;
      cpu_clk_en_o   <= 1'b1;
      flash_clk_en_o <= 1'b1;
      io_clk_en_o    <= 1'b1;
      adc_clk_en_o   <= 1'b1;
      osc_en_o       <= 1'b1;
      mod_clk_en_o   <= {`SPC_GATE_W{1'b1}};
      mod_acc_en_o   <= {`SPC_GATE_W{1'b1}};
      adc_start_o    <= 1'b0;
      adc_ext_o      <= 1'b1;
      adc_en_q       <= 1'b0;
      det_en_o       <= 1'b0;
      acmp_off_o     <= 1'b0;
      vref_en_o      <= 1'b0;
      pin_buf_en_o   <= {`SPC_PIN_W{1'b1}};
    end else if (clk_en_i) begin
      // zero wait state; unmapped reads as zero, writes dropped
      hrdata_o <= 32'h00000000;
      if (take & ~hwrite_i) begin
        case (haddr_i)
          `SPC_A_CTRL: hrdata_o <= {24'h000000, off_q, 1'b0, permit_q, sel_q,
                                    (unlock_cnt_q != 3'h0), 2'h0};
          `SPC_A_GATE: hrdata_o <= {{(32-`SPC_GATE_W){1'b0}}, gate_q};
          `SPC_A_STAT: hrdata_o <= stat;
          default:     hrdata_o <= 32'h00000000;
        endcase
      end
      hreadyout_o    <= 1'b1;
      hresp_o        <= 1'b0;
      cpu_clk_en_o   <= (st_q == ST_RUN);
      flash_clk_en_o <= (st_q == ST_RUN);
      io_clk_en_o    <= io_on;
      adc_clk_en_o   <= adc_on;
      osc_en_o       <= ~(in_sleep & (mode_q == `SPC_MODE_PD));
      mod_clk_en_o   <= dom_on & ~gate_q;
      mod_acc_en_o   <= ~gate_q;
      // converter enable is never touched here; only conversions are started
      adc_start_o    <= sleep_go & adc_en_i & (sel_q != `SPC_MODE_PD);
      adc_en_q       <= adc_en_i;
      if (adc_en_q & ~adc_en_i)
        adc_ext_o <= 1'b1;
      else if (adc_done_i)
        adc_ext_o <= 1'b0;
      det_en_o       <= det_on;
      acmp_off_o     <= acmp_dis;
      vref_en_o      <= det_on | acmp_ref | adc_en_i;
      pin_buf_en_o   <= buf_off ? WAKE_PINS : {`SPC_PIN_W{1'b1}};
    end
  end

endmodule

// ==== shared/spc_regs.vh ====
// register map, field positions and timing constants of the sleep controller
`ifndef SPC_REGS_VH
`define SPC_REGS_VH

`define SPC_AW          8
`define SPC_A_CTRL      8'h00
`define SPC_A_GATE      8'h04
`define SPC_A_STAT      8'h08

`define SPC_B_UNLOCK    2
`define SPC_B_MODE_LO   3
`define SPC_B_MODE_HI   4
`define SPC_B_PERMIT    5
`define SPC_B_OFF       7

`define SPC_MODE_IDLE   2'h0
`define SPC_MODE_NR     2'h1
`define SPC_MODE_PD     2'h2
`define SPC_MODE_RSV    2'h3

`define SPC_GATE_W      4
`define SPC_G_ADC       0

`define SPC_UNLOCK_WIN  3'h4
`define SPC_OFF_DELAY   3'h3
`define SPC_OFF_HOLD    3'h3
`define SPC_HALT_CYC    16'h0004

`define SPC_CLK_MHZ     25
`define SPC_T_OSC_NS    1000
`define SPC_T_RST_NS    64000
`define SPC_FUSE_OFF    2'h3

`define SPC_HTRANS_NSEQ 2'h2
`define SPC_PIN_W       6

`endif

// ==== testbench/spc_sleep_ctrl_asserts.sv ====
// concurrent checks on the sleep controller ports
module spc_sleep_chk #(
  parameter [5:0] WAKE_PINS = 6'h3F
) (
  input wire logic       ref_clk_i,     // clock
  input wire logic       rst_n_i,       // sync reset
  input wire logic       hreadyout_o,   // bus ready
  input wire logic       hresp_o,       // bus response
  input wire logic       sleep_instr_i, // sleep pulse
  input wire logic       adc_en_i,      // converter on
  input wire logic       acmp_iref_i,   // comparator ref
  input wire logic       cpu_clk_en_o,  // cpu clock
  input wire logic       io_clk_en_o,   // io clock
  input wire logic       adc_clk_en_o,  // adc clock
  input wire logic       osc_en_o,      // oscillator
  input wire logic [3:0] mod_clk_en_o,  // module clocks
  input wire logic [3:0] mod_acc_en_o,  // module access
  input wire logic       adc_start_o,   // start pulse
  input wire logic       det_en_o,      // detector on
  input wire logic       acmp_off_o,    // comparator off
  input wire logic [5:0] pin_buf_en_o   // input buffers
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus stalled or errored");
  a_entry_cause: assert property ($fell(cpu_clk_en_o) |-> $past(sleep_instr_i, 2))
    else $error("cpu stopped without sleep");
  a_start_cause: assert property (adc_start_o |-> $past(sleep_instr_i) && $past(adc_en_i))
    else $error("stray conversion start");
  a_domain_order: assert property (!io_clk_en_o |-> !cpu_clk_en_o)
    else $error("io stopped with cpu running");
  a_osc_halts: assert property (!osc_en_o |-> !io_clk_en_o && !adc_clk_en_o && !cpu_clk_en_o)
    else $error("clock runs without oscillator");
  a_buf_wake: assert property (pin_buf_en_o == ((io_clk_en_o || adc_clk_en_o) ? 6'h3F : WAKE_PINS))
    else $error("input buffers wrong");
  a_gate_freeze: assert property ((mod_clk_en_o & ~mod_acc_en_o) == 4'h0)
    else $error("gated module still clocked");
  a_gate_domain: assert property ((io_clk_en_o || mod_clk_en_o[3:1] == 3'h0) && (adc_clk_en_o || !mod_clk_en_o[0]))
    else $error("module clock without domain");
  a_acmp_off: assert property (acmp_off_o |-> !cpu_clk_en_o && !$past(acmp_iref_i))
    else $error("comparator forced off wrongly");
  a_det_off: assert property ($fell(det_en_o) |-> !osc_en_o)
    else $error("detector off outside power-down");
  a_det_wake: assert property ($rose(cpu_clk_en_o) |-> det_en_o)
    else $error("detector still off after wake");
endmodule

bind spc_sleep_ctrl spc_sleep_chk #(.WAKE_PINS(WAKE_PINS)) u_spc_sleep_chk (.*);

// ==== testbench/spc_wake_model.sv ====
// wake sources: each raised request is held until the cpu runs again
module spc_wake_model (
  input  wire logic       ref_clk_i,    // system clock
  input  wire logic       cpu_clk_en_i, // cpu running
  input  wire logic [5:0] raise_i,      // one-cycle requests
  output logic      [5:0] wake_o        // held wake lines
);
  timeunit 1ns;
  timeprecision 1ps;
  initial wake_o = 6'h00;
  // a level source only drops once its handler has run
  always @(posedge ref_clk_i) begin
    wake_o <= raise_i | (wake_o & {6{~cpu_clk_en_i}});
  end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the sleep controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i, rst_n_i, clk_en_i, hsel_i, hwrite_i, sleep_instr_i, adc_en_i, acmp_en_i, acmp_iref_i;
  logic [7:0]  haddr_i;
  logic [1:0]  htrans_i, det_fuse_i;
  logic [2:0]  hsize_i;
  logic [31:0] hwdata_i, hrdata_o, d;
  logic        hreadyout_o, hresp_o, cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, adc_clk_en_o, osc_en_o;
  logic        adc_start_o, adc_ext_o, det_en_o, acmp_off_o, vref_en_o;
  logic [3:0]  mod_clk_en_o, mod_acc_en_o;
  logic [5:0]  pin_buf_en_o, raise;
  wire         irq_any_i, adc_done_i, nvm_ready_i, ext0_level_i, pin_change_i, serial_start_i;
  wire         hready_i = hreadyout_o;
  int          num_errors, compares, cyc, ni, nn, np, no;

  spc_sleep_ctrl #(.OSC_CYC(16'h0003), .RST_CYC(16'h0008), .WAKE_PINS(6'h15)) u_spc_sleep_ctrl (.*);
  spc_wake_model u_spc_wake_model (.ref_clk_i(ref_clk_i), .cpu_clk_en_i(cpu_clk_en_o), .raise_i(raise),
    .wake_o({serial_start_i, pin_change_i, ext0_level_i, nvm_ready_i, adc_done_i, irq_any_i}));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task test_done;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      test_done;
    end
  end

  task automatic chk(input logic [31:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // address phase held until ready, then data phase until ready
  task automatic ap(input logic [7:0] a, input logic w, input logic [31:0] v);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= v;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    ap(a, 1'b1, v);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    ap(a, 1'b0, 32'h0);
    v = hrdata_o;
  endtask

  task automatic pulse(input logic [5:0] b);
    raise <= b;
    @(posedge ref_clk_i);
    raise <= 6'h00;
  endtask

  // sleep, check domains, try wrong wake sources, then wake and count cycles
  task automatic nap(input logic [1:0] m, input logic [5:0] bad, good, input logic [4:0] ck,
                     input logic [2:0] an, output int n);
    sleep_instr_i <= 1'b1;
    @(posedge ref_clk_i);
    sleep_instr_i <= 1'b0;
    // start pulse stands one cycle only: look mid-cycle, off the launch edge
    @(negedge ref_clk_i);
    chk(adc_start_o, adc_en_i && m != 2'h2, "conversion start");
    @(negedge ref_clk_i);
    chk({cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, adc_clk_en_o, osc_en_o}, ck, "clocks");
    @(posedge ref_clk_i);
    pulse(bad);
    repeat (12) @(posedge ref_clk_i);
    chk({cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, adc_clk_en_o, osc_en_o}, ck, "stray wake");
    chk(mod_clk_en_o, {{3{ck[2]}}, ck[1]}, "module clocks");
    chk(pin_buf_en_o, ck[2:1] != 2'h0 ? 6'h3F : 6'h15, "input buffers");
    chk({det_en_o, acmp_off_o, vref_en_o}, an, "analog");
    pulse(good);
    n = 0;
    while (cpu_clk_en_o !== 1'b1 && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(cpu_clk_en_o, 1, "wake");
    $display("sleep mode %0d done", m);
  endtask

  initial begin
    {hsel_i, hwrite_i, sleep_instr_i, adc_en_i, acmp_en_i, acmp_iref_i, rst_n_i} = 7'h00;
    {haddr_i, htrans_i, hwdata_i, raise, det_fuse_i} = 0;
    hsize_i = 3'h2;
    clk_en_i = 1'b1;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk(adc_ext_o, 1, "extended after reset");
    rd(8'h00, d);
    chk(d, 0, "control reset");
    rd(8'h0C, d);
    chk(d, 0, "unmapped read");
    wr(8'h00, 32'h80);
    wr(8'h00, 32'h84);
    repeat (5) @(posedge ref_clk_i);
    wr(8'h00, 32'h80);
    repeat (3) @(posedge ref_clk_i);
    rd(8'h00, d);
    chk(d & 32'h80, 0, "unsequenced off bit");
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, i ? 32'h38 : 32'h10);
      sleep_instr_i <= 1'b1;
      @(posedge ref_clk_i);
      sleep_instr_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      chk(cpu_clk_en_o, 1, "sleep refused");
    end
    $display("refusals done");
    wr(8'h04, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    chk({mod_clk_en_o, mod_acc_en_o}, 8'hEE, "gated");
    rd(8'h04, d);
    chk(d, 1, "gate readback");
    wr(8'h04, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    chk({mod_clk_en_o, mod_acc_en_o}, 8'hFF, "ungated");
    $display("gating done");
    adc_en_i <= 1'b1;
    acmp_en_i <= 1'b1;
    wr(8'h00, 32'h20);
    nap(2'h0, 6'h00, 6'h01, 5'h07, 3'h5, ni);
    wr(8'h00, 32'h28);
    nap(2'h1, 6'h21, 6'h02, 5'h03, 3'h5, nn);
    chk(adc_ext_o, 0, "extended cleared");
    wr(8'h00, 32'h30);
    nap(2'h2, 6'h07, 6'h10, 5'h00, 3'h7, np);
    adc_en_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk(adc_ext_o, 1, "extended after off");
    wr(8'h00, 32'h84);
    wr(8'h00, 32'hB0);
    repeat (3) @(posedge ref_clk_i);
    nap(2'h2, 6'h07, 6'h20, 5'h00, 3'h2, no);
    chk(det_en_o, 1, "detector back");
    chk(32'(no - np), 32'h5, "reset-length wake");
    chk(32'(nn), 32'(ni), "halt length");
    test_done;
  end
endmodule
